// File: hw/uhtd_code_enc.sv
// Result code encoder for one finished transaction
`timescale 1ns/100ps
module uhtd_code_enc
  import uhtd_pkg::*;
(
  // Outcome
  input  wire uhtd_res_t  res,
  input  wire uhtd_dir_t  dir,
  // Limits
  input  wire logic [9:0] mps,
  input  wire logic [9:0] remain,
  // Code
  output logic [3:0]      code,
  output logic            data_ok
);
  logic is_in;
  assign is_in = (dir == UHTD_DIR_IN);

  // Handshake faults outrank data size faults
  always_comb
  begin
    if (res.stall)
      code = UHTD_RC_STALL;
    else if (res.no_resp)
      code = UHTD_RC_NORESP;
    else if (res.pid_check)
      code = UHTD_RC_PIDCHK;
    else if (res.bad_pid)
      code = UHTD_RC_BADPID;
    else if (res.mem_slow)
      code = is_in ? UHTD_RC_MEMWR : UHTD_RC_MEMRD;
    else if (is_in && (res.count > mps || res.count > remain))
      code = UHTD_RC_OVER;
    else if (is_in && res.count < mps && res.count < remain)
      code = UHTD_RC_SHORT;
    else
      code = UHTD_RC_OK;
  end

  assign data_ok = (code == UHTD_RC_OK) || (code == UHTD_RC_SHORT);
endmodule : uhtd_code_enc

// File: hw/uhtd_pkg.sv
// Constants, types and layout for the transfer descriptor header interpreter
package uhtd_pkg;
  // Clock and frame timing
  localparam int unsigned UHTD_CLK_MHZ      = 250;
  localparam int unsigned UHTD_FRAME_US     = 1000;
  localparam int unsigned UHTD_FRAME_CYCLES = UHTD_FRAME_US * UHTD_CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] UHTD_OFS_HDR0 = 8'h00;
  localparam logic [7:0] UHTD_OFS_HDR1 = 8'h04;
  localparam logic [7:0] UHTD_OFS_CTRL = 8'h08;
  localparam logic [7:0] UHTD_OFS_STAT = 8'h0c;

  // Header word 0 fields (bytes 0..3)
  localparam int unsigned UHTD_W0_ACT  = 0;
  localparam int unsigned UHTD_W0_TOG  = 10;
  localparam int unsigned UHTD_W0_RUN  = 11;
  localparam int unsigned UHTD_W0_CODE = 12;
  localparam int unsigned UHTD_W0_MPS  = 16;
  localparam int unsigned UHTD_W0_SPD  = 26;
  localparam int unsigned UHTD_W0_LAST = 27;
  localparam int unsigned UHTD_W0_EP   = 28;
  // Header word 1 fields (bytes 4..7)
  localparam int unsigned UHTD_W1_TOT  = 0;
  localparam int unsigned UHTD_W1_DIR  = 10;
  localparam int unsigned UHTD_W1_RATE = 13;
  localparam int unsigned UHTD_W1_ADDR = 16;
  localparam int unsigned UHTD_W1_FMT  = 23;
  localparam logic [31:0] UHTD_W1_MASK = 32'h00ff_2fff;
  localparam logic [31:0] UHTD_HDR_RST = 32'h0000_0000;
  localparam int unsigned UHTD_CTRL_GO = 0;

  // Result codes
  localparam logic [3:0] UHTD_RC_OK     = 4'h0;
  localparam logic [3:0] UHTD_RC_STALL  = 4'h4;
  localparam logic [3:0] UHTD_RC_NORESP = 4'h5;
  localparam logic [3:0] UHTD_RC_PIDCHK = 4'h6;
  localparam logic [3:0] UHTD_RC_BADPID = 4'h7;
  localparam logic [3:0] UHTD_RC_OVER   = 4'h8;
  localparam logic [3:0] UHTD_RC_SHORT  = 4'h9;
  localparam logic [3:0] UHTD_RC_MEMWR  = 4'hc;
  localparam logic [3:0] UHTD_RC_MEMRD  = 4'hd;

  typedef enum logic [1:0] {
    UHTD_DIR_SETUP = 2'b00,
    UHTD_DIR_OUT   = 2'b01,
    UHTD_DIR_IN    = 2'b10,
    UHTD_DIR_RSVD  = 2'b11
  } uhtd_dir_t;

  typedef enum logic [2:0] {
    UHTD_ST_IDLE   = 3'b000,
    UHTD_ST_CHECK  = 3'b001,
    UHTD_ST_ISSUE  = 3'b010,
    UHTD_ST_WAIT   = 3'b011,
    UHTD_ST_FINISH = 3'b100
  } uhtd_state_t;

  // Token request to the bus engine
  typedef struct packed {
    uhtd_dir_t   dir;
    logic [6:0]  addr;
    logic [3:0]  ep;
    logic        low_speed;
    logic        iso;
    logic        toggle;
    logic [9:0]  len;
  } uhtd_tok_t;

  // Transaction outcome from the bus engine
  typedef struct packed {
    logic        done;
    logic [9:0]  count;
    logic        stall;
    logic        no_resp;
    logic        pid_check;
    logic        bad_pid;
    logic        mem_slow;
  } uhtd_res_t;
endpackage : uhtd_pkg

// File: hw/uhtd_rate_gate.sv
// Per-frame transaction allowance for rate-limited endpoints
`timescale 1ns/100ps
module uhtd_rate_gate
  import uhtd_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = UHTD_FRAME_CYCLES
)
(
  // Clock, reset and enable
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Control
  input  wire logic fire,
  input  wire logic limit_on,
  output logic      allow
);
  localparam int unsigned CW = $clog2(FRAME_CYCLES);

  // Counter needs at least two states to wrap
  if (FRAME_CYCLES < 2)
  begin : g_bad_frame
    $error("FRAME_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          used;
    logic [1:0]    fires;
  } uhtd_gate_state_t;

  uhtd_gate_state_t q;
  uhtd_gate_state_t n;
  logic             wrap;

  assign wrap  = (q.cnt == CW'(FRAME_CYCLES - 1));
  assign allow = !q.used;

  always_comb
  begin
    n = q;
    n.cnt = wrap ? '0 : q.cnt + 1'b1;
    // a fire at the frame edge still counts
    n.used = fire | (q.used & !wrap);
    if (wrap)
      n.fires = {1'b0, fire};
    else if (fire && q.fires != 2'b11)
      n.fires = q.fires + 2'b01;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;
    else if (ce)
      q <= n;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);

  property p_one_per_frame;
    limit_on |-> q.fires <= 2'b01;
  endproperty
  a_one_per_frame: assert property (p_one_per_frame)
    else $error("more than one limited transaction in a frame");

  property p_allow_after_wrap;
    wrap && !fire |=> allow;
  endproperty
  a_allow_after_wrap: assert property (p_allow_after_wrap)
    else $error("allowance not restored at frame start");

  c_frame_edge: cover property (wrap && q.used);
endmodule : uhtd_rate_gate

// File: hw/uhtd_top.sv
// Transfer descriptor header interpreter with AHB-Lite register access
`timescale 1ns/100ps
module uhtd_top
  import uhtd_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = UHTD_FRAME_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Token request to bus engine
  output logic             tok_valid,
  input  wire logic        tok_ready,
  output uhtd_tok_t        tok,
  // Outcome from bus engine
  input  wire uhtd_res_t   res,
  // Descriptor status
  output logic             busy,
  output logic             list_end
);
  typedef struct packed {
    logic [31:0]  hdr0;
    logic [31:0]  hdr1;
    uhtd_state_t  st;
    logic         done;
    logic         skipped;
    logic         list_end;
    logic [3:0]   code;
    logic         a_wr;
    logic [7:0]   a_addr;
    logic [31:0]  rdata;
    logic         tok_valid;
    uhtd_tok_t    tok;
  } uhtd_top_state_t;

  uhtd_top_state_t q;
  uhtd_top_state_t n;

  // Header fields
  logic [9:0]  actual;
  logic        toggle;
  logic        active;
  logic [9:0]  mps;
  logic        low_speed;
  logic        last;
  logic [3:0]  ep;
  logic [9:0]  total;
  uhtd_dir_t   dir;
  logic        rate_bit;
  logic [6:0]  fn_addr;
  logic        iso;

  assign actual    = q.hdr0[UHTD_W0_ACT +: 10];
  assign toggle    = q.hdr0[UHTD_W0_TOG];
  assign active    = q.hdr0[UHTD_W0_RUN];
  assign mps       = q.hdr0[UHTD_W0_MPS +: 10];
  assign low_speed = q.hdr0[UHTD_W0_SPD];
  assign last      = q.hdr0[UHTD_W0_LAST];
  assign ep        = q.hdr0[UHTD_W0_EP +: 4];
  assign total     = q.hdr1[UHTD_W1_TOT +: 10];
  assign dir       = uhtd_dir_t'(q.hdr1[UHTD_W1_DIR +: 2]);
  assign rate_bit  = q.hdr1[UHTD_W1_RATE];
  assign fn_addr   = q.hdr1[UHTD_W1_ADDR +: 7];
  assign iso       = q.hdr1[UHTD_W1_FMT];

  // Derived transfer quantities
  logic [9:0]  remain;
  logic [9:0]  pkt_len;
  logic [9:0]  actual_new;
  logic        rate_on;
  logic        allow;
  logic        fire;
  logic        res_take;
  logic [3:0]  enc_code;
  logic        data_ok;
  logic        acc;
  logic        map_ok;
  logic [31:0] stat_word;

  // byte count may exceed one packet
  assign remain     = total - actual;
  // never more than the packet limit
  assign pkt_len    = (mps < remain) ? mps : remain;
  assign actual_new = actual + res.count;
  assign rate_on    = rate_bit & !iso;
  assign fire       = (q.st == UHTD_ST_ISSUE) && (!rate_on || allow);
  // Outcome is looked at only once the token was taken
  assign res_take   = (q.st == UHTD_ST_WAIT) && !q.tok_valid && res.done;

  uhtd_code_enc u_code_enc (
    .res     (res),
    .dir     (dir),
    .mps     (mps),
    .remain  (remain),
    .code    (enc_code),
    .data_ok (data_ok)
  );

  uhtd_rate_gate #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) u_rate_gate (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .fire     (fire && rate_on),
    .limit_on (rate_on),
    .allow    (allow)
  );

  // Zero-wait slave; a frozen block stalls the bus
  assign acc       = hsel && htrans[1] && hready && (hsize == 3'b010);
  assign map_ok    = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign stat_word = {28'h000_0000, q.list_end, q.skipped, q.done,
                      (q.st != UHTD_ST_IDLE)};

  always_comb
  begin
    n = q;
    // Data phase of a write
    if (q.a_wr)
    begin
      unique case (q.a_addr)
        // Header locked while the descriptor is in flight
        UHTD_OFS_HDR0:
          if (q.st == UHTD_ST_IDLE)
            n.hdr0 = hwdata;
        UHTD_OFS_HDR1:
          if (q.st == UHTD_ST_IDLE)
            n.hdr1 = hwdata & UHTD_W1_MASK;
        UHTD_OFS_CTRL:
          if (hwdata[UHTD_CTRL_GO] && q.st == UHTD_ST_IDLE)
          begin
            n.st       = UHTD_ST_CHECK;
            n.done     = 1'b0;
            n.skipped  = 1'b0;
            n.list_end = 1'b0;
          end
        default:
          n.a_wr = 1'b0;
      endcase
    end
    n.a_wr   = acc && hwrite && map_ok;
    n.a_addr = haddr[7:0];
    // Address phase of a read
    if (acc && !hwrite)
    begin
      if (!map_ok)
        n.rdata = 32'h0000_0000;
      else if (haddr[7:0] == UHTD_OFS_HDR0)
        n.rdata = q.hdr0;
      else if (haddr[7:0] == UHTD_OFS_HDR1)
        n.rdata = q.hdr1;
      else if (haddr[7:0] == UHTD_OFS_STAT)
        n.rdata = stat_word;
      else
        n.rdata = 32'h0000_0000;
    end

    if (q.tok_valid && tok_ready)
      n.tok_valid = 1'b0;

    unique case (q.st)
      UHTD_ST_IDLE:
        n.st = n.st;
      UHTD_ST_CHECK:
        if (!active)
        begin
          n.st      = UHTD_ST_IDLE;
          n.done    = 1'b1;
          n.skipped = 1'b1;
        end
        else if (dir == UHTD_DIR_RSVD)
        begin
          n.code = UHTD_RC_BADPID;
          n.st   = UHTD_ST_FINISH;
        end
        else
          n.st = UHTD_ST_ISSUE;
      UHTD_ST_ISSUE:
        if (fire)
        begin
          n.tok_valid     = 1'b1;
          n.tok.dir       = dir;
          n.tok.addr      = fn_addr;
          n.tok.ep        = ep;
          n.tok.low_speed = low_speed;
          n.tok.iso       = iso;
          n.tok.toggle    = toggle;
          n.tok.len       = pkt_len;
          n.st            = UHTD_ST_WAIT;
        end
      UHTD_ST_WAIT:
        if (res_take)
        begin
          n.code = enc_code;
          if (data_ok)
          begin
            n.hdr0[UHTD_W0_TOG]       = !toggle;
            n.hdr0[UHTD_W0_ACT +: 10] = actual_new;
          end
          // keep going while packets come back full
          if (enc_code == UHTD_RC_OK && !iso && actual_new != total)
            n.st = UHTD_ST_ISSUE;
          else
            n.st = UHTD_ST_FINISH;
        end
      UHTD_ST_FINISH:
      begin
        // retire: cleared so it is skipped next time
        n.hdr0[UHTD_W0_RUN]       = 1'b0;
        n.hdr0[UHTD_W0_CODE +: 4] = q.code;
        n.list_end                = last;
        n.done                    = 1'b1;
        n.st                      = UHTD_ST_IDLE;
      end
      default:
        n.st = UHTD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q      <= '0;
      q.hdr0 <= UHTD_HDR_RST;
      q.hdr1 <= UHTD_HDR_RST;
    end
    else if (ce)
      q <= n;
  end

  assign hrdata    = q.rdata;
  assign tok_valid = q.tok_valid;
  assign tok       = q.tok;
  assign busy      = (q.st != UHTD_ST_IDLE);
  assign list_end  = q.list_end;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);

  property p_run_only_active;
    $rose(q.tok_valid) |-> active;
  endproperty
  a_run_only_active: assert property (p_run_only_active)
    else $error("token issued for an inactive descriptor");

  property p_retire;
    q.st == UHTD_ST_FINISH |=> !active && q.done && !busy;
  endproperty
  a_retire: assert property (p_retire)
    else $error("descriptor not retired on completion");

  property p_ep;
    q.tok_valid |-> q.tok.ep == ep && q.tok.low_speed == low_speed;
  endproperty
  a_ep: assert property (p_ep)
    else $error("token endpoint or speed differs from header");

  property p_addr;
    q.tok_valid |-> q.tok.addr == fn_addr;
  endproperty
  a_addr: assert property (p_addr)
    else $error("token function address differs from header");

  property p_len;
    q.tok_valid |-> q.tok.len <= mps;
  endproperty
  a_len: assert property (p_len)
    else $error("packet length above endpoint limit");

  property p_stall;
    res_take && res.stall |-> ##2 q.hdr0[UHTD_W0_CODE +: 4] == 4'h4 && !active;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall not written back as 0100");

  property p_noresp;
    res_take && !res.stall && res.no_resp
      |-> ##2 q.hdr0[UHTD_W0_CODE +: 4] == 4'h5;
  endproperty
  a_noresp: assert property (p_noresp)
    else $error("no response not written back as 0101");

  property p_toggle;
    res_take && data_ok |=> toggle != $past(toggle);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle did not advance after good packet");

  property p_clean;
    res_take && enc_code == UHTD_RC_OK && actual_new == total
      |-> ##2 q.hdr0[UHTD_W0_CODE +: 4] == 4'h0 && q.done;
  endproperty
  a_clean: assert property (p_clean)
    else $error("clean finish not written back as 0000");

  c_skip:  cover property (q.st == UHTD_ST_CHECK && !active);
  c_multi: cover property (res_take ##1 q.st == UHTD_ST_ISSUE);
  c_stall: cover property (res_take && res.stall);
  c_short: cover property (res_take && enc_code == UHTD_RC_SHORT);
endmodule : uhtd_top

// File: tb/uhtd_engine_model.sv
// Far-side bus engine model: takes tokens, answers with a commanded outcome
`timescale 1ns/100ps
module uhtd_engine_model
  import uhtd_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Commanded behaviour
  input  wire logic [3:0] lag,
  input  wire uhtd_res_t  outcome,
  // Token and result
  input  wire logic       tok_valid,
  output logic            tok_ready,
  input  wire uhtd_tok_t  tok,
  output uhtd_res_t       res
);
  logic [1:0] st;
  logic [3:0] cnt;

  always @(posedge clk)
  begin
    // Outside the done pulse the fields carry junk, never the last answer
    res <= {1'h0, ~outcome[14:0]};
    if (reset)
    begin
      st <= 2'h0;
      cnt <= 4'h0;
      tok_ready <= 1'h0;
    end
    else
    begin
      case (st)
        2'h0:
          if (tok_valid)
          begin
            cnt <= lag;
            st <= 2'h1;
          end
        2'h1:
          if (cnt == 4'h0)
          begin
            tok_ready <= 1'h1;
            st <= 2'h2;
          end
          else
            cnt <= cnt - 4'h1;
        2'h2:
        begin
          // Extra cycle so the answer never lands before tok_valid drops
          tok_ready <= 1'h0;
          cnt <= lag + 4'h1;
          st <= 2'h3;
        end
        default:
          if (cnt == 4'h0)
          begin
            res <= {1'h1, outcome[14:0]};
            st <= 2'h0;
          end
          else
            cnt <= cnt - 4'h1;
      endcase
    end
  end
endmodule : uhtd_engine_model

// File: tb/uhtd_top_tb.sv
// Self-checking bench for the descriptor header interpreter
`timescale 1ns/100ps
module uhtd_top_tb
  import uhtd_pkg::*;
;
  typedef struct packed {
    logic [1:0] dir;
    logic       tog;
    logic       spd;
    logic [3:0] ep;
    logic [6:0] fa;
    logic [4:0] out;
    logic [9:0] cnt;
    logic [3:0] code;
  } uhtd_row_t;
  // Outcome bits: stall, no_resp, pid_check, bad_pid, mem_slow
  localparam uhtd_row_t ROWS [10] = '{
    '{2'h2, 1'h0, 1'h0, 4'h1, 7'h05, 5'h00, 10'h8, 4'h0},
    '{2'h1, 1'h1, 1'h1, 4'h2, 7'h7f, 5'h10, 10'h0, 4'h4},
    '{2'h2, 1'h0, 1'h0, 4'h3, 7'h01, 5'h08, 10'h0, 4'h5},
    '{2'h1, 1'h1, 1'h0, 4'h4, 7'h22, 5'h04, 10'h0, 4'h6},
    '{2'h2, 1'h0, 1'h1, 4'h5, 7'h33, 5'h02, 10'h0, 4'h7},
    '{2'h2, 1'h1, 1'h0, 4'h6, 7'h44, 5'h01, 10'h8, 4'hc},
    '{2'h1, 1'h0, 1'h0, 4'h7, 7'h55, 5'h01, 10'h8, 4'hd},
    '{2'h2, 1'h1, 1'h1, 4'h8, 7'h66, 5'h00, 10'h9, 4'h8},
    '{2'h2, 1'h0, 1'h0, 4'hf, 7'h0a, 5'h00, 10'h4, 4'h9},
    '{2'h0, 1'h1, 1'h1, 4'h0, 7'h11, 5'h00, 10'h8, 4'h0}};

  logic        clk;
  logic        reset;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        tok_valid;
  logic        tok_ready;
  logic        busy;
  logic        list_end;
  logic        g;
  logic        ce;
  logic [31:0] q_exp;
  logic [3:0]  m_lag;
  uhtd_tok_t   tok;
  uhtd_tok_t   tok_cap;
  uhtd_res_t   res;
  uhtd_res_t   m_out;
  uhtd_row_t   r;
  int          err_total;
  int          compares;
  int          cyc;
  int          n0;
  int          tok_at[$];

  uhtd_top #(.FRAME_CYCLES(64)) u_uhtd_top (
    .clk(clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tok_valid(tok_valid), .tok_ready(tok_ready), .tok(tok), .res(res),
    .busy(busy), .list_end(list_end));

  uhtd_engine_model u_uhtd_engine_model (
    .clk(clk), .reset(reset), .lag(m_lag), .outcome(m_out),
    .tok_valid(tok_valid), .tok_ready(tok_ready), .tok(tok), .res(res));

  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (tok_valid === 1'h1 && tok_ready === 1'h1)
    begin
      tok_cap = tok;
      tok_at.push_back(cyc);
    end
    // Generous ceiling; the whole sequence needs under two thousand cycles
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  function automatic logic [31:0] mk0(logic [3:0] ep, logic last, logic spd,
                                      logic [3:0] code, logic act, logic tog,
                                      logic [9:0] n);
    return {ep, last, spd, 10'h8, code, act, tog, n};
  endfunction : mk0

  function automatic logic [31:0] mk1(logic fmt, logic [6:0] fa, logic rate,
                                      logic [1:0] dir, logic [9:0] tot);
    return {8'h00, fmt, fa, 2'h0, rate, 1'h0, dir, tot};
  endfunction : mk1

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd_q);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'h1)
      @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'h1)
      @(posedge clk);
    rd_q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, {24'h0, a}, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'h0, {24'h0, a}, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic go(input logic [31:0] h0, input logic [31:0] h1,
                    input logic [3:0] lag, input uhtd_res_t o);
    m_lag <= lag;
    m_out <= o;
    n0 = tok_at.size();
    wr(UHTD_OFS_HDR0, h0);
    wr(UHTD_OFS_HDR1, h1);
    wr(UHTD_OFS_CTRL, 32'h1);
  endtask : go

  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'h0 && n < 2000)
    begin
      n++;
      @(posedge clk);
    end
    // A descriptor that never retires is a failure
    if (n == 2000)
      err_total++;
  endtask : idle

  task automatic summarize();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'h0;
    reset = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    ce = 1'h1;
    m_lag = 4'h0;
    m_out = '0;
    err_total = 0;
    compares = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rd(UHTD_OFS_HDR0, 32'h0);
    rd(UHTD_OFS_HDR1, 32'h0);
    rd(UHTD_OFS_CTRL, 32'h0);
    rd(UHTD_OFS_STAT, 32'h0);
    ahb(1'h1, 32'h0000_0010, 32'hffff_ffff, q);
    rd(8'h10, 32'h0);
    ahb(1'h0, 32'h0000_0100, 32'h0, q);
    chk(q, 32'h0);
    // Rows cover every result code and every direction except the reserved one
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      go(mk0(r.ep, 1'h0, r.spd, 4'h0, 1'h1, r.tog, 10'h0),
         mk1(1'h0, r.fa, 1'h0, r.dir, 10'h8), i[0] ? 4'h5 : 4'h0, {1'h0, r.cnt, r.out});
      idle();
      g = (r.code == 4'h0 || r.code == 4'h9);
      q_exp = mk0(r.ep, 1'h0, r.spd, r.code, 1'h0, r.tog ^ g, g ? r.cnt : 10'h0);
      rd(UHTD_OFS_HDR0, q_exp);
      chk(32'(tok_at.size() - n0), 32'h1);
      chk(32'(tok_cap),
          {6'h0, r.dir, r.fa, r.ep, r.spd, 1'h0, r.tog, 10'h8});
      rd(UHTD_OFS_STAT, 32'h2);
    end
    // Inactive descriptor is skipped without a token
    go(mk0(4'h1, 1'h0, 1'h0, 4'h0, 1'h0, 1'h0, 10'h0), mk1(1'h0, 7'h05, 1'h0, 2'h2, 10'h8),
       4'h0, {1'h0, 10'h8, 5'h00});
    idle();
    rd(UHTD_OFS_STAT, 32'h6);
    chk(32'(tok_at.size() - n0), 32'h0);
    // Reserved direction finishes at once
    go(mk0(4'h2, 1'h0, 1'h0, 4'h0, 1'h1, 1'h0, 10'h0), mk1(1'h0, 7'h05, 1'h0, 2'h3, 10'h8),
       4'h0, {1'h0, 10'h8, 5'h00});
    idle();
    rd(UHTD_OFS_HDR0, mk0(4'h2, 1'h0, 1'h0, 4'h7, 1'h0, 1'h0, 10'h0));
    chk(32'(tok_at.size() - n0), 32'h0);
    // Isochronous: one packet only, even with bytes left
    go(mk0(4'h3, 1'h0, 1'h0, 4'h0, 1'h1, 1'h0, 10'h0), mk1(1'h1, 7'h09, 1'h0, 2'h1, 10'h10),
       4'h3, {1'h0, 10'h8, 5'h00});
    // Frozen block must neither advance nor issue a token
    ce <= 1'h0;
    repeat (30) @(posedge clk);
    chk({31'h0, busy}, 32'h1);
    chk(32'(tok_at.size() - n0), 32'h0);
    ce <= 1'h1;
    idle();
    rd(UHTD_OFS_HDR0, mk0(4'h3, 1'h0, 1'h0, 4'h0, 1'h0, 1'h1, 10'h8));
    chk(32'(tok_at.size() - n0), 32'h1);
    chk({31'h0, tok_cap.iso}, 32'h1);
    // Rate-limited three-packet list end, header writes refused while busy
    go(mk0(4'h4, 1'h1, 1'h0, 4'h0, 1'h1, 1'h0, 10'h0), mk1(1'h0, 7'h0c, 1'h1, 2'h1, 10'h18),
       4'h0, {1'h0, 10'h8, 5'h00});
    repeat (4) @(posedge clk);
    wr(UHTD_OFS_HDR1, 32'h0);
    rd(UHTD_OFS_HDR1, mk1(1'h0, 7'h0c, 1'h1, 2'h1, 10'h18));
    idle();
    rd(UHTD_OFS_HDR0, mk0(4'h4, 1'h1, 1'h0, 4'h0, 1'h0, 1'h1, 10'h18));
    rd(UHTD_OFS_STAT, 32'ha);
    chk({31'h0, list_end}, 32'h1);
    chk(32'(tok_at.size() - n0), 32'h3);
    chk({31'h0, tok_cap.toggle}, 32'h0);
    // Three tokens in three frames span more than one whole frame
    chk({31'h0, (tok_at[n0 + 2] - tok_at[n0]) > 64}, 32'h1);
    summarize();
  end
endmodule : uhtd_top_tb
